// [hw/ovf_map.svh]
// Command codes, field positions, reset values and timing for the over-voltage fault block
`ifndef OVF_MAP_SVH
`define OVF_MAP_SVH

// Command codes of the three registers
`define OVF_CMD_IOUT_OFS 8'h39
`define OVF_CMD_OV_LIMIT 8'h40
`define OVF_CMD_OV_ACTION 8'h41

// Action byte field positions
`define OVF_RESP_HI 7
`define OVF_RESP_LO 6
`define OVF_RETRY_HI 5
`define OVF_RETRY_LO 3
`define OVF_DELAY_HI 2
`define OVF_DELAY_LO 0

// Response codes
`define OVF_RESP_IGNORE 2'h0
`define OVF_RESP_DELAY 2'h1
`define OVF_RESP_DISABLE 2'h2
`define OVF_RESP_HOLD 2'h3

// Retry codes
`define OVF_RETRY_NONE 3'h0
`define OVF_RETRY_FOREVER 3'h7

// Reset values
`define OVF_RST_IOUT_OFS 16'h0000
`define OVF_RST_OV_LIMIT 16'h7fff
`define OVF_RST_OV_ACTION 8'h80

// Linear current format: exponent in 15:11, signed mantissa in 10:0
`define OVF_LIN_EXP_LO 11
`define OVF_LIN_MANT_HI 10

// Fault delay time unit and clock period in ns; cycles per unit derived from them
`define OVF_UNIT_NS 1000000
`define OVF_CLK_NS 40
`define OVF_UNIT_CYC ((`OVF_UNIT_NS) / (`OVF_CLK_NS))

`endif

// [hw/ovf_pkg.sv]
// Types shared by the over-voltage fault block
package ovf_pkg;

    // Response state of the fault handler
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DELAY,
        ST_OFF,
        ST_ATTEMPT,
        ST_LATCH,
        ST_HOLD
    } ovf_state_e;

    // Fault action byte
    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retries;
        logic [2:0] delay;
    } ovf_action_s;

    // One command from the bus engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } ovf_cmd_s;

    // Number of delay units coded by a three-bit field
    function automatic logic [7:0] ovf_units(input logic [2:0] f);
        return 8'h01 << f;
    endfunction

endpackage

// [hw/ovf_regs.sv]
// Command registers of the over-voltage fault block
`include "ovf_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ovf_regs
    import ovf_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic reset, // Synchronous reset
    input wire ovf_cmd_s cmd, // Command from the bus engine
    output logic [15:0] offset_q, // Current reading offset
    output logic [15:0] limit_q, // Fault threshold
    output ovf_action_s action_q, // Fault action byte
    output logic [15:0] rd_data_q, // Read answer
    output logic rd_valid_q, // Read answer valid pulse
    output logic cmd_err_q // Unsupported command pulse
);

    logic [15:0] offset_d;
    logic [15:0] limit_d;
    ovf_action_s action_d;
    logic [15:0] rd_data_d;
    logic rd_valid_d;
    logic cmd_err_d;
    logic hit;

    // Decode writes and reads
    always_comb begin
        offset_d = offset_q;
        limit_d = limit_q;
        action_d = action_q;
        rd_data_d = 16'h0000;
        rd_valid_d = cmd.rd;
        hit = 1'b1;
        case (cmd.code)
            `OVF_CMD_IOUT_OFS: begin
                if (cmd.wr) begin
                    offset_d = cmd.data;
                end
                rd_data_d = offset_q;
            end
            `OVF_CMD_OV_LIMIT: begin
                if (cmd.wr) begin
                    limit_d = cmd.data;
                end
                rd_data_d = limit_q;
            end
            `OVF_CMD_OV_ACTION: begin
                if (cmd.wr) begin
                    action_d = ovf_action_s'(cmd.data[7:0]);
                end
                rd_data_d = {8'h00, action_q};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        cmd_err_d = (cmd.wr | cmd.rd) & ~hit;
    end

    // Register the file
    always_ff @(posedge mclk) begin
        if (reset) begin
            offset_q <= `OVF_RST_IOUT_OFS;
            limit_q <= `OVF_RST_OV_LIMIT;
            action_q <= ovf_action_s'(`OVF_RST_OV_ACTION);
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end else begin
            offset_q <= offset_d;
            limit_q <= limit_d;
            action_q <= action_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            cmd_err_q <= cmd_err_d;
        end
    end

endmodule

`default_nettype wire

// [hw/ovf_timer.sv]
// Delay and retry interval timer counting whole fault delay units
`timescale 1ns/100ps
`default_nettype none

module ovf_timer #(
    parameter int UNIT_CYCLES = 25000
) (
    input wire logic mclk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic start, // Load and start, restarts if busy
    input wire logic [7:0] units, // Units to count
    output logic busy_q, // Counting
    output logic done_q // Expiry pulse
);

    localparam int PW = $clog2(UNIT_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYCLES - 1);
    // The first unit is one cycle short because done is registered, so expiry lands exactly units x unit cycles
    // after start; needs at least two cycles per unit
    localparam logic [PW-1:0] PRE_FIRST = PW'(UNIT_CYCLES - 2);

    logic [PW-1:0] pre_q;
    logic [PW-1:0] pre_d;
    logic [7:0] units_q;
    logic [7:0] units_d;
    logic busy_d;
    logic done_d;

    // Prescale to units, then count units down
    always_comb begin
        pre_d = pre_q;
        units_d = units_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start) begin
            pre_d = PRE_FIRST;
            units_d = units;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (pre_q == '0) begin
                pre_d = PRE_LAST;
                if (units_q == 8'h01) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    units_d = units_q - 8'h01;
                end
            end else begin
                pre_d = pre_q - PW'(1);
            end
        end
    end

    // Timer state
    always_ff @(posedge mclk) begin
        if (reset) begin
            pre_q <= '0;
            units_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            units_q <= units_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

endmodule

`default_nettype wire

// [hw/ovf_top.sv]
// Output over-voltage fault detection and response with its command registers
`include "ovf_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ovf_top
    import ovf_pkg::*;
#(
    parameter int UNIT_CYCLES = `OVF_UNIT_CYC
) (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic reset, // Synchronous reset, bias power-up
    input wire ovf_cmd_s cmd, // Command from the bus engine
    input wire logic [15:0] vout_meas, // Measured output voltage, exponent -11
    input wire logic [15:0] iout_raw, // Raw current reading, linear format
    input wire logic clear_faults, // Clear-faults command pulse
    input wire logic status_clear, // Individual status bit clear pulse
    input wire logic operation_on, // On command from the operation register
    input wire logic ctrl_pin, // Remote control pin, asynchronous
    output logic [15:0] rd_data_q, // Read answer
    output logic rd_valid_q, // Read answer valid pulse
    output logic cmd_err_q, // Unsupported command pulse
    output logic [15:0] iout_reading_q, // Corrected current reading
    output logic output_enable_q, // Converter output enable
    output logic ov_fault_q, // Latched fault status bit
    output logic restart_q // Restart attempt pulse
);

    logic [15:0] offset_q;
    logic [15:0] limit_q;
    ovf_action_s act;
    logic tmr_start;
    logic [7:0] tmr_units;
    logic tmr_busy;
    logic tmr_done;
    logic ctrl_s1_q;
    logic ctrl_s2_q;
    logic on_prev_q;
    logic on_now;
    logic on_rise;
    logic clr_any;
    logic fault_now;
    ovf_state_e st_q;
    ovf_state_e st_d;
    logic [2:0] tries_q;
    logic [2:0] tries_d;
    logic restart_d;
    logic oe_d;
    logic ov_fault_d;
    logic [15:0] iout_d;
    logic signed [11:0] mant_sum;

    // Command registers
    ovf_regs u_regs (
        .mclk(mclk),
        .reset(reset),
        .cmd(cmd),
        .offset_q(offset_q),
        .limit_q(limit_q),
        .action_q(act),
        .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q),
        .cmd_err_q(cmd_err_q)
    );

    // Delay and retry interval timer
    ovf_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .reset(reset),
        .start(tmr_start),
        .units(tmr_units),
        .busy_q(tmr_busy),
        .done_q(tmr_done)
    );

    // Interval length in delay units from the action byte
    assign tmr_units = ovf_units(act.delay);

    // Fault comparison, both sides in the same exponent so a plain unsigned compare
    assign fault_now = vout_meas > limit_q;

    // Combined on command and its off-then-on edge
    assign on_now = ctrl_s2_q & operation_on;
    assign on_rise = on_now & ~on_prev_q;
    assign clr_any = status_clear | clear_faults | on_rise;

    // Status bit: a fault in the clearing cycle keeps it set
    always_comb begin
        ov_fault_d = fault_now | (ov_fault_q & ~clr_any);
    end

    // Current reading offset added to the mantissa with saturation
    always_comb begin
        mant_sum = 12'(signed'(iout_raw[`OVF_LIN_MANT_HI:0])) + 12'(signed'(offset_q[`OVF_LIN_MANT_HI:0]));
        iout_d = {iout_raw[15:`OVF_LIN_EXP_LO], mant_sum[10:0]};
        if (mant_sum > 12'sh3ff) begin
            iout_d[10:0] = 11'h3ff;
        end else if (mant_sum < -12'sh400) begin
            iout_d[10:0] = 11'h400;
        end
    end

    // Fault response sequencer
    always_comb begin
        st_d = st_q;
        tries_d = tries_q;
        tmr_start = 1'b0;
        restart_d = 1'b0;
        case (st_q)
            ST_RUN: begin
                if (fault_now) begin
                    case (act.resp)
                        `OVF_RESP_IGNORE: begin
                            st_d = ST_RUN;
                        end
                        `OVF_RESP_DELAY: begin
                            tmr_start = 1'b1;
                            st_d = ST_DELAY;
                        end
                        `OVF_RESP_DISABLE: begin
                            if (act.retries == `OVF_RETRY_NONE) begin
                                st_d = ST_LATCH;
                            end else begin
                                tmr_start = 1'b1;
                                st_d = ST_OFF;
                            end
                        end
                        default: begin
                            st_d = ST_HOLD;
                        end
                    endcase
                end
            end
            ST_DELAY: begin
                // Output stays on; the fault is judged only at expiry
                if (tmr_done) begin
                    if (!fault_now) begin
                        st_d = ST_RUN;
                    end else if (act.retries == `OVF_RETRY_NONE) begin
                        st_d = ST_LATCH;
                    end else begin
                        tmr_start = 1'b1;
                        st_d = ST_OFF;
                    end
                end
            end
            ST_OFF: begin
                // Next attempt starts one full interval after the previous start
                if (tmr_done) begin
                    tries_d = tries_q + 3'h1;
                    restart_d = 1'b1;
                    tmr_start = 1'b1;
                    st_d = ST_ATTEMPT;
                end
            end
            ST_ATTEMPT: begin
                if (fault_now) begin
                    if (act.retries != `OVF_RETRY_FOREVER && tries_q >= act.retries) begin
                        st_d = ST_LATCH;
                    end else begin
                        if (tmr_done) begin
                            tmr_start = 1'b1;
                        end
                        st_d = ST_OFF;
                    end
                end else if (tmr_done) begin
                    tries_d = 3'h0;
                    st_d = ST_RUN;
                end
            end
            ST_LATCH: begin
                if (clr_any) begin
                    tries_d = 3'h0;
                    st_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!fault_now) begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
        // Commanded off ends any response and forgets retries
        if (!on_now) begin
            st_d = ST_RUN;
            tries_d = 3'h0;
            restart_d = 1'b0;
        end
    end

    // Output enable follows the next state
    always_comb begin
        oe_d = on_now && st_d != ST_OFF && st_d != ST_LATCH && st_d != ST_HOLD;
    end

    // Synchroniser for the control pin
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_s1_q <= 1'b0;
            ctrl_s2_q <= 1'b0;
        end else begin
            ctrl_s1_q <= ctrl_pin;
            ctrl_s2_q <= ctrl_s1_q;
        end
    end

    // Sequencer and output registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= ST_RUN;
            tries_q <= 3'h0;
            on_prev_q <= 1'b0;
            ov_fault_q <= 1'b0;
            output_enable_q <= 1'b0;
            restart_q <= 1'b0;
            iout_reading_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            tries_q <= tries_d;
            on_prev_q <= on_now;
            ov_fault_q <= ov_fault_d;
            output_enable_q <= oe_d;
            restart_q <= restart_d;
            iout_reading_q <= iout_d;
        end
    end

    // Helper: cycles between restart pulses
    logic [31:0] gap_q;
    logic seen_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= restart_q ? 32'h1 : gap_q + 32'h1;
            seen_q <= (restart_q | seen_q) & (st_q != ST_RUN);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence fault_in_run(logic [1:0] r);
        st_q == ST_RUN && act.resp == r && fault_now && on_now;
    endsequence

    ignore_keeps_on_a: assert property (fault_in_run(`OVF_RESP_IGNORE) |=> output_enable_q && st_q == ST_RUN)
        else $error("output dropped under ignore response");
    delay_keeps_on_a: assert property (fault_in_run(`OVF_RESP_DELAY) |=> st_q == ST_DELAY ##0 output_enable_q)
        else $error("output dropped during fault delay");
    disable_now_a: assert property (fault_in_run(`OVF_RESP_DISABLE) |=> !output_enable_q)
        else $error("output not disabled on fault");
    hold_resume_a: assert property (st_q == ST_HOLD && !fault_now && on_now |=> output_enable_q && st_q == ST_RUN)
        else $error("output did not resume after fault cleared");
    clear_latch_a: assert property (st_q == ST_LATCH && clr_any && on_now |=> st_q == ST_RUN)
        else $error("latched fault not cleared");
    no_retry_a: assert property (fault_in_run(`OVF_RESP_DISABLE) ##0 act.retries == 3'h0 |=> st_q == ST_LATCH)
        else $error("retry attempted with zero retries");
    retry_limit_a: assert property (act.retries != 3'h7 |-> tries_q <= act.retries)
        else $error("more attempts than retry setting");
    retry_gap_a: assert property (restart_q && seen_q |-> gap_q == 32'(tmr_units) * 32'(UNIT_CYCLES))
        else $error("restart spacing wrong");
    fault_status_a: assert property (fault_now |=> ov_fault_q)
        else $error("fault status not set");

endmodule

`default_nettype wire

// [tb/ovf_host.sv]
// Host model that issues register commands to the fault block
`timescale 1ns/100ps
`default_nettype none

module ovf_host
    import ovf_pkg::*;
(
    input wire logic mclk, // System clock
    output ovf_cmd_s cmd, // Command to the block
    input wire logic [15:0] rd_data_q, // Read answer
    input wire logic rd_valid_q, // Read answer valid
    input wire logic cmd_err_q // Unsupported command
);
    // Bus idle until the first command
    initial begin
        cmd = '0;
    end

    // One-cycle command; a released bus shows inverted code and data, not the last value
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] rdata, output logic valid, output logic err);
        @(posedge mclk);
        cmd <= '{wr: wr, rd: !wr, code: code, data: data};
        @(posedge mclk);
        cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
        @(negedge mclk);
        rdata = rd_data_q;
        valid = rd_valid_q;
        err = cmd_err_q;
    endtask
endmodule
`default_nettype wire

// [tb/ovf_top_tb.sv]
// Self-checking testbench of the over-voltage fault block
`timescale 1ns/100ps
`default_nettype none

module ovf_top_tb;
    import ovf_pkg::*;
    localparam int UNIT = 4;
    logic mclk;
    logic reset;
    ovf_cmd_s cmd;
    logic [15:0] vout_meas;
    logic [15:0] iout_raw;
    logic clear_faults;
    logic status_clear;
    logic operation_on;
    logic ctrl_pin;
    logic [15:0] rd_data_q;
    logic rd_valid_q;
    logic cmd_err_q;
    logic [15:0] iout_reading_q;
    logic output_enable_q;
    logic ov_fault_q;
    logic restart_q;
    int bad_count = 0;
    int total_checks = 0;

    ovf_top #(.UNIT_CYCLES(UNIT)) dut_u (.mclk(mclk), .reset(reset), .cmd(cmd), .vout_meas(vout_meas),
        .iout_raw(iout_raw), .clear_faults(clear_faults), .status_clear(status_clear),
        .operation_on(operation_on), .ctrl_pin(ctrl_pin), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .cmd_err_q(cmd_err_q), .iout_reading_q(iout_reading_q), .output_enable_q(output_enable_q),
        .ov_fault_q(ov_fault_q), .restart_q(restart_q));

    ovf_host host_u (.mclk(mclk), .cmd(cmd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .cmd_err_q(cmd_err_q));

    // Clock at 25 MHz
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Counts a comparison and reports a difference
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits whole cycles and settles on the falling edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        logic [15:0] d;
        logic v;
        logic e;
        host_u.xfer(1'b1, code, data, d, v, e);
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic exp_err);
        logic [15:0] d;
        logic v;
        logic e;
        host_u.xfer(1'b0, code, 16'h0000, d, v, e);
        check(16'(v), 16'h0001);
        check(16'(e), 16'(exp_err));
        check(d, exp);
    endtask

    task automatic set_vout(input logic [15:0] v);
        @(posedge mclk);
        vout_meas <= v;
    endtask

    // Removes the fault, clears the status and expects the output back on
    task automatic clr();
        set_vout(16'h0000);
        @(posedge mclk);
        clear_faults <= 1'b1;
        @(posedge mclk);
        clear_faults <= 1'b0;
        tick(40);
        check(16'(ov_fault_q), 16'h0000);
        check(16'(output_enable_q), 16'h0001);
    endtask

    // Reset values, read-back, action byte width and an unmapped code
    task automatic t_regs();
        rd_chk(8'h39, 16'h0000, 1'b0);
        rd_chk(8'h40, 16'h7fff, 1'b0);
        rd_chk(8'h41, 16'h0080, 1'b0);
        rd_chk(8'h42, 16'h0000, 1'b1);
        wr(8'h40, 16'h8000);
        wr(8'h41, 16'h12c5);
        rd_chk(8'h40, 16'h8000, 1'b0);
        rd_chk(8'h41, 16'h00c5, 1'b0);
    endtask

    // Unsigned threshold compare; ignore response keeps the output on
    task automatic t_ignore();
        wr(8'h41, 16'h0000);
        set_vout(16'h8000);
        tick(4);
        check(16'(ov_fault_q), 16'h0000);
        set_vout(16'h8001);
        tick(4);
        check(16'(ov_fault_q), 16'h0001);
        check(16'(output_enable_q), 16'h0001);
        clr();
    endtask

    // Disable with no retry stays latched; two more ways of clearing
    task automatic t_latch();
        wr(8'h41, 16'h0080);
        set_vout(16'hffff);
        tick(2);
        check(16'(output_enable_q), 16'h0000);
        set_vout(16'h0000);
        tick(60);
        check(16'(output_enable_q), 16'h0000);
        @(posedge mclk);
        status_clear <= 1'b1;
        @(posedge mclk);
        status_clear <= 1'b0;
        tick(4);
        check(16'(ov_fault_q), 16'h0000);
        check(16'(output_enable_q), 16'h0001);
        set_vout(16'h8001);
        set_vout(16'h0000);
        tick(4);
        check(16'(output_enable_q), 16'h0000);
        @(posedge mclk);
        operation_on <= 1'b0;
        tick(4);
        @(posedge mclk);
        operation_on <= 1'b1;
        tick(4);
        check(16'(ov_fault_q), 16'h0000);
        check(16'(output_enable_q), 16'h0001);
    endtask

    // Counts restart attempts and their spacing under a standing fault
    task automatic t_retry(input logic [2:0] retries, input logic [2:0] delay, input int win, input int exp_n);
        int n;
        int last;
        int gap;
        n = 0;
        last = -1;
        gap = 0;
        wr(8'h41, {8'h00, 2'b10, retries, delay});
        set_vout(16'h9000);
        for (int i = 0; i < win; i++) begin
            @(negedge mclk);
            if (restart_q === 1'b1) begin
                if (last >= 0) gap = i - last;
                last = i;
                n++;
            end
        end
        check(16'(n), 16'(exp_n));
        if (exp_n > 1) check(16'(gap), 16'((1 << delay) * UNIT));
        if (retries != 3'h7) check(16'(output_enable_q), 16'h0000);
        clr();
    endtask

    // Delayed response: on through the delay, off after it if the fault stays
    task automatic t_delay();
        wr(8'h41, 16'h0042);
        set_vout(16'h8001);
        tick(12);
        check(16'(output_enable_q), 16'h0001);
        tick(10);
        check(16'(output_enable_q), 16'h0000);
        clr();
        set_vout(16'h8001);
        tick(5);
        set_vout(16'h0000);
        tick(30);
        check(16'(output_enable_q), 16'h0001);
        clr();
    endtask

    // Hold response: off only while the fault stands
    task automatic t_hold();
        wr(8'h41, 16'h00c0);
        set_vout(16'h8001);
        tick(3);
        check(16'(output_enable_q), 16'h0000);
        set_vout(16'h0000);
        tick(3);
        check(16'(output_enable_q), 16'h0001);
        clr();
        // Control pin off, then back on
        @(posedge mclk);
        ctrl_pin <= 1'b0;
        tick(4);
        check(16'(output_enable_q), 16'h0000);
        @(posedge mclk);
        ctrl_pin <= 1'b1;
        tick(4);
        check(16'(output_enable_q), 16'h0001);
    endtask

    // Offset added to the current mantissa, exponent kept
    task automatic t_offset();
        wr(8'h39, 16'h0005);
        @(posedge mclk);
        iout_raw <= 16'h080a;
        tick(3);
        check(iout_reading_q, 16'h080f);
        wr(8'h39, 16'h07fb);
        tick(3);
        check(iout_reading_q, 16'h0805);
        wr(8'h39, 16'h03ff);
        tick(3);
        check(iout_reading_q, 16'h0bff);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        vout_meas = 16'h0000;
        iout_raw = 16'h0000;
        clear_faults = 1'b0;
        status_clear = 1'b0;
        operation_on = 1'b1;
        ctrl_pin = 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        tick(6);
        t_regs();
        t_ignore();
        t_latch();
        for (int r = 1; r <= 6; r++) t_retry(3'(r), 3'h1, (r + 3) * 8, r);
        t_retry(3'h7, 3'h2, 136, 8);
        t_delay();
        t_hold();
        t_offset();
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(40 * 20000);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
